// file: hdl/pcdc_device_control.sv
// device control upper bits of a switch port, behind an avalon-mm slave
// What this block does
// - relaxed ordering enable, bit 4, is read-only zero, reset 0.
// - bits 7:5 hold a read-write max payload size code, reset 000b.
// - a written payload code above the supported maximum stores that maximum.
// - extended tag bit 8 and phantom function bit 9 read zero, reset 0.
// - bit 10 is sticky read-write aux power enable, reset 0.
// - no snoop enable, bit 11, is read-only zero, reset 0.
// - max read request size, bits 14:12, hardwired read-only 000b.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`default_nettype none
module pcdc_device_control (
    // clock and resets
    input wire logic clock,
    input wire logic rstn,
    input wire logic por_rstn,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic [1:0] response,
    output logic waitrequest,
    // supported payload limit from the capability register
    input wire logic [2:0] mps_supported,
    // settings to the port logic
    output logic [2:0] mps_setting,
    output logic aux_pwr_en
);
    pcdc_pkg::pcdc_req_s req;
    pcdc_pkg::pcdc_rsp_s rsp_q;
    pcdc_pkg::pcdc_rsp_s rsp_d;
    pcdc_pkg::pcdc_bus_e state_q;
    pcdc_pkg::pcdc_bus_e state_d;
    logic wait_q;
    logic wait_d;
    logic [2:0] mps_q;
    logic [2:0] mps_d;
    logic clamp_q;
    logic clamp_d;
    logic [2:0] mps_eff;
    logic mps_over;
    logic aux_q;
    logic hit_ctrl;
    logic hit_stat;
    logic commit;
    logic wr_mps;
    logic wr_aux;
    logic clr_clamp;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    always_comb begin
        req.address = address;
        req.read = read;
        req.write = write;
        req.writedata = writedata;
        req.byteenable = byteenable;
    end

    always_comb begin
        hit_ctrl = pcdc_pkg::pcdc_hit(req.address, pcdc_pkg::OFF_CTRL);
        hit_stat = pcdc_pkg::pcdc_hit(req.address, pcdc_pkg::OFF_STAT);
    end

    pcdc_mps_clamp u_clamp (
        .req_code(req.writedata[pcdc_pkg::MPS_MSB:pcdc_pkg::MPS_LSB]),
        .cap_code(mps_supported),
        .eff_code(mps_eff),
        .clamped(mps_over)
    );

    // control word as software sees it; only two fields are live
    always_comb begin
        ctrl_word = pcdc_pkg::WORD_ZERO;
        ctrl_word[pcdc_pkg::RLXO_BIT] = pcdc_pkg::FIXED_ZERO;
        ctrl_word[pcdc_pkg::MPS_MSB:pcdc_pkg::MPS_LSB] = mps_q;
        ctrl_word[pcdc_pkg::XTAG_BIT] = pcdc_pkg::FIXED_ZERO;
        ctrl_word[pcdc_pkg::PHFN_BIT] = pcdc_pkg::FIXED_ZERO;
        ctrl_word[pcdc_pkg::AUXP_BIT] = aux_q;
        ctrl_word[pcdc_pkg::NSNP_BIT] = pcdc_pkg::FIXED_ZERO;
        ctrl_word[pcdc_pkg::MRRS_MSB:pcdc_pkg::MRRS_LSB] = pcdc_pkg::MRRS_VAL;
        ctrl_word[pcdc_pkg::RSVD_BIT] = pcdc_pkg::FIXED_ZERO;
    end

    always_comb begin
        stat_word = pcdc_pkg::WORD_ZERO;
        stat_word[pcdc_pkg::CAP_MSB:pcdc_pkg::CAP_LSB] = mps_supported;
        stat_word[pcdc_pkg::CLMP_BIT] = clamp_q;
    end

    // bus sequencer: one wait cycle per request, answer on the second
    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        rsp_d = rsp_q;
        commit = 1'b0;
        case (state_q)
            pcdc_pkg::PCDC_IDLE: begin
                if (req.read || req.write) begin
                    state_d = pcdc_pkg::PCDC_ANSWER;
                    wait_d = 1'b0;
                    rsp_d.response = pcdc_pkg::RESP_OKAY;
                    if (req.read && hit_ctrl) begin
                        rsp_d.readdata = ctrl_word;
                    end else if (req.read && hit_stat) begin
                        rsp_d.readdata = stat_word;
                    end else begin
                        rsp_d.readdata = pcdc_pkg::WORD_ZERO;
                    end
                    if (!hit_ctrl && !hit_stat) begin
                        rsp_d.response = pcdc_pkg::RESP_DECERR;
                    end
                end
            end
            pcdc_pkg::PCDC_ANSWER: begin
                // the master samples waitrequest low at this edge
                commit = req.write;
                state_d = pcdc_pkg::PCDC_IDLE;
                wait_d = 1'b1;
            end
            default: begin
                state_d = pcdc_pkg::PCDC_IDLE;
                wait_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= pcdc_pkg::PCDC_IDLE;
            wait_q <= 1'b1;
            rsp_q <= '0;
        end else begin
            state_q <= state_d;
            wait_q <= wait_d;
            rsp_q <= rsp_d;
        end
    end

    // write strobes; fixed and reserved bits have no storage at all
    always_comb begin
        wr_mps = commit && hit_ctrl && req.byteenable[pcdc_pkg::MPS_LANE];
        wr_aux = commit && hit_ctrl && req.byteenable[pcdc_pkg::AUXP_LANE];
        clr_clamp = commit && hit_stat && req.byteenable[pcdc_pkg::CLMP_LANE]
            && req.writedata[pcdc_pkg::CLMP_BIT];
    end

    always_comb begin
        mps_d = wr_mps ? mps_eff : mps_q;
        // a new clamp in the clearing cycle keeps the flag set
        clamp_d = (wr_mps && mps_over) || (clamp_q && !clr_clamp);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mps_q <= pcdc_pkg::MPS_RST;
            clamp_q <= pcdc_pkg::CLMP_RST;
        end else begin
            mps_q <= mps_d;
            clamp_q <= clamp_d;
        end
    end

    pcdc_sticky_bit u_aux (
        .clock(clock),
        .por_rstn(por_rstn),
        .wr_en(wr_aux),
        .wr_val(req.writedata[pcdc_pkg::AUXP_BIT]),
        .q(aux_q)
    );

    assign readdata = rsp_q.readdata;
    assign response = rsp_q.response;
    assign waitrequest = wait_q;
    assign mps_setting = mps_q;
    assign aux_pwr_en = aux_q;
endmodule
`default_nettype wire

// file: hdl/pcdc_mps_clamp.sv
// payload size code limiter against the advertised supported maximum
`default_nettype none
module pcdc_mps_clamp (
    // requested and supported codes
    input wire logic [2:0] req_code,
    input wire logic [2:0] cap_code,
    // stored code and clamp indication
    output logic [2:0] eff_code,
    output logic clamped
);
    always_comb begin
        clamped = req_code > cap_code;
        eff_code = clamped ? cap_code : req_code;
    end
endmodule
`default_nettype wire

// file: hdl/pcdc_pkg.sv
// constants, types and helpers for the device control upper register bank
`default_nettype none
package pcdc_pkg;
    // register bus geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;
    // byte offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STAT = 4'h4;
    // control word field positions
    localparam int unsigned RLXO_BIT = 4;
    localparam int unsigned MPS_LSB = 5;
    localparam int unsigned MPS_MSB = 7;
    localparam int unsigned XTAG_BIT = 8;
    localparam int unsigned PHFN_BIT = 9;
    localparam int unsigned AUXP_BIT = 10;
    localparam int unsigned NSNP_BIT = 11;
    localparam int unsigned MRRS_LSB = 12;
    localparam int unsigned MRRS_MSB = 14;
    localparam int unsigned RSVD_BIT = 15;
    // status word field positions
    localparam int unsigned CAP_LSB = 0;
    localparam int unsigned CAP_MSB = 2;
    localparam int unsigned CLMP_BIT = 8;
    // byte lanes that carry the writable fields
    localparam int unsigned MPS_LANE = 0;
    localparam int unsigned AUXP_LANE = 1;
    localparam int unsigned CLMP_LANE = 1;
    // reset and fixed values
    localparam logic [2:0] MPS_RST = 3'h0;
    localparam logic AUXP_RST = 1'h0;
    localparam logic CLMP_RST = 1'h0;
    localparam logic FIXED_ZERO = 1'h0;
    localparam logic [2:0] MRRS_VAL = 3'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0;
    // avalon response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum {
        PCDC_IDLE,
        PCDC_ANSWER
    } pcdc_bus_e;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } pcdc_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic [1:0] response;
    } pcdc_rsp_s;

    // word-aligned address match
    function automatic logic pcdc_hit(input logic [3:0] addr, input logic [3:0] off);
        return addr[3:2] == off[3:2];
    endfunction
endpackage
`default_nettype wire

// file: hdl/pcdc_sticky_bit.sv
// one sticky read-write bit, cleared only by the power-on reset
`default_nettype none
module pcdc_sticky_bit (
    // clock and power-on reset
    input wire logic clock,
    input wire logic por_rstn,
    // write port
    input wire logic wr_en,
    input wire logic wr_val,
    // stored value
    output logic q
);
    logic q_q;
    logic q_d;

    always_comb begin
        q_d = wr_en ? wr_val : q_q;
    end

    // ordinary reset is not wired here so the bit survives it
    always_ff @(posedge clock or negedge por_rstn) begin
        if (!por_rstn) begin
            q_q <= pcdc_pkg::AUXP_RST;
        end else begin
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule
`default_nettype wire

// file: testbench/pcdc_device_control_props.sv
// assertions on the ports of the device control register bank
`default_nettype none
module pcdc_device_control_props (
    // clock and resets
    input wire logic clock, rstn, por_rstn,
    // avalon-mm slave
    input wire logic [3:0] address, byteenable,
    input wire logic read, write, waitrequest,
    input wire logic [31:0] writedata, readdata,
    input wire logic [1:0] response,
    // port settings
    input wire logic [2:0] mps_supported, mps_setting,
    input wire logic aux_pwr_en
);
    default clocking dcb @(posedge clock); endclocking
    default disable iff (!rstn);
    wire logic ctrl_rd = read && !waitrequest && address[3:2] == 2'h0;
    wire logic ctrl_wr = write && !waitrequest && address[3:2] == 2'h0;
    wire logic [2:0] clamp_exp = writedata[7:5] > mps_supported ? mps_supported : writedata[7:5];
    wait_one_a: assert property ($fell(waitrequest) |=> waitrequest)
        else $error("waitrequest low too long");
    take_req_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered");
    rlx_zero_a: assert property (ctrl_rd |-> !readdata[4])
        else $error("bit 4 set");
    mps_read_a: assert property (ctrl_rd |-> readdata[7:5] == mps_setting)
        else $error("payload field mismatch");
    mps_clamp_a: assert property (
        ctrl_wr && byteenable[0] |=> mps_setting == $past(clamp_exp))
        else $error("payload code not clamped");
    xtag_zero_a: assert property (ctrl_rd |-> readdata[9:8] == 2'h0)
        else $error("bits 9:8 set");
    aux_write_a: assert property (ctrl_wr && byteenable[1] |=> aux_pwr_en == $past(writedata[10]))
        else $error("aux enable not written");
    nsnp_zero_a: assert property (ctrl_rd |-> !readdata[11])
        else $error("bit 11 set");
    mrrs_zero_a: assert property (ctrl_rd |-> readdata[14:12] == 3'h0)
        else $error("bits 14:12 set");
    // ordinary reset must not touch the sticky bit, so only power-on reset disables
    aux_keep_a: assert property (disable iff (!por_rstn)
        !(ctrl_wr && byteenable[1]) |=> $stable(aux_pwr_en))
        else $error("aux enable changed");
endmodule
bind pcdc_device_control pcdc_device_control_props u_props (.clock, .rstn, .por_rstn, .address,
    .byteenable, .read, .write, .waitrequest, .writedata, .readdata, .response,
    .mps_supported, .mps_setting, .aux_pwr_en);
`default_nettype wire

// file: testbench/tb_pcdc_device_control.sv
// self-checking bench for the device control register bank
`default_nettype none
module tb_pcdc_device_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rstn, por_rstn, read, write, waitrequest, aux_pwr_en, aux_m, clamp_m;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, d;
    logic [1:0] response;
    logic [2:0] mps_supported, mps_setting, mps_m;
    logic [34:0] exp_q[$];
    logic [34:0] e;
    int n_mismatch, n_compared;
    pcdc_device_control DUT (.clock, .rstn, .por_rstn, .address, .read, .write, .writedata,
        .byteenable, .readdata, .response, .waitrequest, .mps_supported, .mps_setting,
        .aux_pwr_en);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic check(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    always @(posedge clock) begin
        if (rstn === 1'b1 && waitrequest === 1'b0 && (read || write) && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(response === e[1:0], "response");
            if (e[34]) check(readdata === e[33:2], "read data");
        end
    end
    // unmapped words sit above 0x7, hence the decode on bit 3
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
            input logic [3:0] be, input logic [31:0] x);
        int n;
        exp_q.push_back({!wr, x, (a[3] ? 2'h3 : 2'h0)});
        @(posedge clock);
        {read, write, address, writedata, byteenable} <= {!wr, wr, a, wd, be};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check(1'b0, "no answer");
        {read, write} <= 2'b00;
    endtask
    task automatic rctrl();
        bus(1'b0, 4'h0, 32'h0, 4'hf, {21'h0, aux_m, 2'h0, mps_m, 5'h0});
        check(mps_setting === mps_m && aux_pwr_en === aux_m, "settings");
    endtask
    task automatic wctrl(input logic [31:0] wd, input logic [3:0] be);
        if (be[0]) begin
            clamp_m |= wd[7:5] > mps_supported;
            mps_m = wd[7:5] > mps_supported ? mps_supported : wd[7:5];
        end
        if (be[1]) aux_m = wd[10];
        bus(1'b1, 4'h0, wd, be, 32'h0);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #20us;
        n_mismatch++;
        conclude();
    end
    initial begin
        {rstn, por_rstn, read, write, address, writedata, byteenable} = '0;
        {mps_supported, mps_m, aux_m, clamp_m} = '0;
        void'($urandom(32'hcf4a06c6));
        repeat (12) @(posedge clock);
        {rstn, por_rstn} <= 2'b11;
        rctrl();
        $display("reset values done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            mps_supported <= 3'($urandom_range(7));
            @(posedge clock);
            d = $urandom;
            d[7:5] = i[2:0];
            wctrl(d, i < 8 ? 4'hf : 4'($urandom));
            rctrl();
            bus(1'b0, 4'h4, 32'h0, 4'hf, {23'h0, clamp_m, 5'h0, mps_supported});
            if (i[0]) clamp_m = 1'b0;
            if (i[0]) bus(1'b1, 4'h4, 32'h100, 4'h2, 32'h0);
        end
        $display("payload codes done");
        bus(1'b0, 4'h8, 32'h0, 4'hf, 32'h0);
        bus(1'b1, 4'hc, 32'hffffffff, 4'hf, 32'h0);
        wctrl(32'h400, 4'h2);
        rctrl();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        {mps_m, clamp_m} = '0;
        rctrl();
        @(posedge clock);
        {rstn, por_rstn} <= 2'b00;
        repeat (3) @(posedge clock);
        {rstn, por_rstn} <= 2'b11;
        aux_m = 1'b0;
        rctrl();
        $display("resets done");
        repeat (4) @(posedge clock);
        check(exp_q.size() == 0, "answers missing");
        conclude();
    end
endmodule
`default_nettype wire
